// *** rtl/wavegen_pkg.sv ***
/*
  Shared constants, register map and carriers of the setpoint waveform unit.
  Assumes one 50 MHz clock and a 4-bit word-addressed register port.
*/
package wavegen_pkg;
  // Timebase
  localparam int unsigned CLOCK_HZ      = 50_000_000;
  localparam int unsigned CLOCK_NS      = 20;
  localparam int unsigned TICK_NS       = 100_000;
  localparam int unsigned TICK_CYCLES   = (TICK_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam longint unsigned PHASE_NUM = 64'h0001_0000_0000_0000;
  localparam logic [23:0] PHASE_SCALE   = 24'(PHASE_NUM / CLOCK_HZ);
  // Parameter bounds, intervals in ticks
  localparam logic [31:0] INTERVAL_MIN  = 32'h0000_0001;
  localparam logic [31:0] INTERVAL_MAX  = 32'h1575_2a00;
  localparam logic [15:0] FREQ_MIN      = 16'h0001;
  localparam logic [15:0] FREQ_MAX      = 16'h2710;
  localparam logic [15:0] NOMINAL_CODE  = 16'hffff;
  // Safe limits applied on entry to generator mode
  localparam logic [15:0] SAFE_LIMIT_U  = 16'h0000;
  localparam logic [15:0] SAFE_LIMIT_I  = 16'h0000;
  localparam logic [15:0] SAFE_LIMIT_P  = 16'h0000;
  // Register offsets
  localparam logic [3:0] ADDR_CMD    = 4'h0;
  localparam logic [3:0] ADDR_FUNC   = 4'h1;
  localparam logic [3:0] ADDR_AMPL   = 4'h2;
  localparam logic [3:0] ADDR_OFFS   = 4'h3;
  localparam logic [3:0] ADDR_FREQ   = 4'h4;
  localparam logic [3:0] ADDR_FIRST  = 4'h5;
  localparam logic [3:0] ADDR_SECOND = 4'h6;
  localparam logic [3:0] ADDR_STAT_U = 4'h7;
  localparam logic [3:0] ADDR_STAT_P = 4'h8;
  localparam logic [3:0] ADDR_LIM_U  = 4'h9;
  localparam logic [3:0] ADDR_LIM_I  = 4'ha;
  localparam logic [3:0] ADDR_LIM_P  = 4'hb;
  // Command bits (write) and status bits (read) at ADDR_CMD
  localparam int CMD_ENTER = 0;
  localparam int CMD_EXIT  = 1;
  localparam int CMD_LOAD  = 2;
  localparam int CMD_START = 3;
  localparam int CMD_STOP  = 4;
  localparam int CMD_CLR_ALARM = 5;
  localparam int CMD_CLR_ERR   = 6;
  // Function register fields and codes
  localparam int FUNC_LSB   = 0;
  localparam int TARGET_LSB = 2;
  localparam logic [1:0] FN_SINE = 2'h0;
  localparam logic [1:0] FN_TRI  = 2'h1;
  localparam logic [1:0] FN_RECT = 2'h2;
  localparam logic [1:0] TARGET_NONE = 2'h0;
  localparam logic [1:0] TARGET_U    = 2'h1;
  localparam logic [1:0] TARGET_I    = 2'h2;

  typedef struct packed {
    logic [1:0]  func;
    logic [1:0]  target;
    logic [15:0] ampl;
    logic [15:0] offs;
    logic [15:0] freq;
    logic [31:0] first_interval_time;
    logic [31:0] second_interval_time;
  } wave_cfg_t;

  typedef struct packed {
    logic [15:0] u;
    logic [15:0] i;
    logic [15:0] p;
  } setpoints_t;

  localparam wave_cfg_t CFG_RESET = '0;
endpackage

// *** rtl/wave_tick.sv ***
/*
  Timebase tick for interval counting, one pulse every TICK_CYCLES clocks.
  Assumes i_run is a registered level from the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module wave_tick #(
  parameter int unsigned TICK_CYCLES = 5000
) (
  input  wire logic i_clock,
  input  wire logic i_rst,
  input  wire logic i_run,
  output logic      o_tick
);
  logic [31:0] count_r;
  logic [31:0] count_nxt;
  logic        tick_nxt;

  always_comb begin
    count_nxt = count_r + 32'h1;
    tick_nxt  = 1'b0;
    if (!i_run) begin
      count_nxt = '0;
    end else if (count_r == 32'(TICK_CYCLES - 1)) begin
      count_nxt = '0;
      tick_nxt  = 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      count_r <= '0;
      o_tick  <= 1'b0;
    end else begin
      count_r <= count_nxt;
      o_tick  <= tick_nxt;
    end
  end
endmodule
`default_nettype wire

// *** rtl/sine_table.sv ***
/*
  Registered sine lookup, quarter-wave table with symmetry, 64 points.
  Assumes the phase word comes from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module sine_table (
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  input  wire logic [5:0]  i_phase,
  output logic signed [15:0] o_sine
);
  localparam logic [15:0] QUARTER [16] = '{
    16'h0000, 16'h0c8c, 16'h18f9, 16'h2528, 16'h30fb, 16'h3c56,
    16'h471c, 16'h5133, 16'h5a82, 16'h62f1, 16'h6a6d, 16'h70e2,
    16'h7641, 16'h7a7c, 16'h7d89, 16'h7f61};
  localparam logic [15:0] PEAK = 16'h7fff;

  logic [3:0]  index;
  logic [15:0] mag;
  logic signed [15:0] sine_nxt;

  always_comb begin
    index = i_phase[4] ? 4'(~i_phase[3:0]) : i_phase[3:0];
    // Falling quarter index 0 lands on the peak, not on zero
    mag = (i_phase[4] && i_phase[3:0] == 4'h0) ? PEAK : QUARTER[index];
    if (i_phase[4] && i_phase[3:0] != 4'h0) begin
      mag = QUARTER[4'(~i_phase[3:0]) + 4'h1];
    end
    sine_nxt = i_phase[5] ? -$signed(mag) : $signed(mag);
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_sine <= '0;
    end else begin
      o_sine <= sine_nxt;
    end
  end
endmodule
`default_nettype wire

// *** rtl/setpoint_waveform_unit.sv ***
/*
  Setpoint waveform unit: sine, triangle and rectangle on U or I setpoint.
  // Overview of operation
  // (R1) Configure only while output is off
  // (R2) Resistance mode blocks function selection
  // (R3) Load needs a chosen target quantity
  // (R4) Waveform drives one setpoint, others limit
  // (R5) Entering generator mode resets limits safely
  // (R6) Load: transfer, statics, output on, arm
  // (R7) Statics are start/end; current starts at zero
  // (R8) Start or button begins wave immediately
  // (R9) Stop halts wave, output stays on
  // (R10) Button stop halts wave, output off
  // (R11) Alarm halts wave, output off, reported
  // (R12) Sine amplitude and offset bounds checked
  // (R13) Sine uses one fixed frequency per run
  // (R14) Triangle rises first, falls second interval
  // (R15) Triangle period is sum of intervals
  // (R16) Triangle offset is foot level, bounded
  // (R17) Rectangle high first, offset level second
  // (R18) Rectangle period is sum, sets duty
  // (R19) Rectangle offset is foot level, bounded
  // (R20) Intervals count 0.1 ms timebase ticks
  Assumes i_alarm and i_r_mode come from logic on this clock and the
  on/off button arrives asynchronously from a pin.
*/
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module setpoint_waveform_unit #(
  parameter int unsigned TICK_CYCLES_P = wavegen_pkg::TICK_CYCLES
) (
  input  wire logic                    i_clock,
  input  wire logic                    i_rst,
  input  wire logic [3:0]              i_addr,
  input  wire logic [31:0]             i_wdata,
  input  wire logic                    i_wr,
  input  wire logic                    i_rd,
  output logic [31:0]                  o_rdata,
  input  wire logic                    i_r_mode,
  input  wire logic                    i_alarm,
  input  wire logic                    i_onoff_button,
  output logic                         o_output_on,
  output logic                         o_running,
  output logic                         o_armed,
  output logic                         o_alarm_report,
  output wavegen_pkg::setpoints_t      o_setpoints,
  output wavegen_pkg::setpoints_t      o_limits
);
  import wavegen_pkg::*;

  typedef enum logic [2:0] {
    ST_NORMAL, ST_CONFIG, ST_XFER, ST_STATIC, ST_OUTON, ST_ARMED, ST_RUN
  } state_t;

  function automatic logic cfg_ok(input wave_cfg_t c);
    logic [16:0] top;
    logic        t_ok;
    top  = {1'b0, c.ampl} + {1'b0, c.offs};
    t_ok = c.first_interval_time >= INTERVAL_MIN &&
           c.first_interval_time <= INTERVAL_MAX &&
           c.second_interval_time >= INTERVAL_MIN &&
           c.second_interval_time <= INTERVAL_MAX;
    cfg_ok = 1'b0;
    if (c.target == TARGET_U || c.target == TARGET_I) begin
      if (c.func == FN_SINE) begin
        cfg_ok = top <= {1'b0, NOMINAL_CODE} && c.offs >= c.ampl &&
                 c.freq >= FREQ_MIN && c.freq <= FREQ_MAX;
      end else if (c.func == FN_TRI || c.func == FN_RECT) begin
        cfg_ok = top <= {1'b0, NOMINAL_CODE} && t_ok;
      end
    end
  endfunction

  function automatic logic [15:0] clamp(input logic [15:0] v,
                                        input logic [15:0] lim);
    clamp = (v > lim) ? lim : v;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Button synchroniser and edge
  logic btn_s1_r;
  logic btn_s2_r;
  logic btn_s3_r;
  logic press;

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      btn_s1_r <= 1'b0;
      btn_s2_r <= 1'b0;
      btn_s3_r <= 1'b0;
    end else begin
      btn_s1_r <= i_onoff_button;
      btn_s2_r <= btn_s1_r;
      btn_s3_r <= btn_s2_r;
    end
  end
  assign press = btn_s2_r && !btn_s3_r;

  //////////////////////////////////////////////////////////////////////////
  // Control state
  state_t     state_r,     state_nxt;
  logic       out_on_r,    out_on_nxt;
  logic       alarm_r,     alarm_nxt;
  logic       err_r,       err_nxt;
  wave_cfg_t  cfg_r,       cfg_nxt;
  wave_cfg_t  run_cfg_r,   run_cfg_nxt;
  setpoints_t stat_r,      stat_nxt;
  setpoints_t lim_r,       lim_nxt;
  logic [31:0] rdata_nxt;
  logic        wr_cmd;
  logic        cmd_start;
  logic        cmd_stop;
  logic        cfg_open;
  logic        active;

  assign wr_cmd    = i_wr && i_addr == ADDR_CMD;
  assign cmd_start = wr_cmd && i_wdata[CMD_START];
  assign cmd_stop  = wr_cmd && i_wdata[CMD_STOP];
  assign cfg_open  = !out_on_r && !i_r_mode;                       // [R1] [R2]
  assign active    = state_r == ST_XFER || state_r == ST_STATIC ||
                     state_r == ST_OUTON || state_r == ST_ARMED ||
                     state_r == ST_RUN;

  always_comb begin
    state_nxt   = state_r;
    out_on_nxt  = out_on_r;
    alarm_nxt   = alarm_r;
    err_nxt     = err_r;
    cfg_nxt     = cfg_r;
    run_cfg_nxt = run_cfg_r;
    stat_nxt    = stat_r;
    lim_nxt     = lim_r;
    // Sticky flags: clear first so a same-cycle event wins
    if (wr_cmd && i_wdata[CMD_CLR_ALARM]) begin
      alarm_nxt = 1'b0;
    end
    if (wr_cmd && i_wdata[CMD_CLR_ERR]) begin
      err_nxt = 1'b0;
    end
    if (i_wr && cfg_open && state_r != ST_NORMAL) begin
      if (i_addr == ADDR_FUNC) begin                               // [R2] [R3]
        cfg_nxt.func   = i_wdata[FUNC_LSB +: 2];
        cfg_nxt.target = i_wdata[TARGET_LSB +: 2];
      end else if (i_addr == ADDR_AMPL) begin
        cfg_nxt.ampl = i_wdata[15:0];
      end else if (i_addr == ADDR_OFFS) begin
        cfg_nxt.offs = i_wdata[15:0];
      end else if (i_addr == ADDR_FREQ) begin
        cfg_nxt.freq = i_wdata[15:0];
      end else if (i_addr == ADDR_FIRST) begin
        cfg_nxt.first_interval_time = i_wdata;
      end else if (i_addr == ADDR_SECOND) begin
        cfg_nxt.second_interval_time = i_wdata;
      end else if (i_addr == ADDR_STAT_U) begin
        stat_nxt.u = i_wdata[15:0];
      end else if (i_addr == ADDR_STAT_P) begin
        stat_nxt.p = i_wdata[15:0];
      end else if (i_addr == ADDR_LIM_U) begin
        lim_nxt.u = i_wdata[15:0];
      end else if (i_addr == ADDR_LIM_I) begin
        lim_nxt.i = i_wdata[15:0];
      end else if (i_addr == ADDR_LIM_P) begin
        lim_nxt.p = i_wdata[15:0];
      end
    end
    case (state_r)
      ST_NORMAL: begin
        if (wr_cmd && i_wdata[CMD_ENTER] && cfg_open) begin        // [R2]
          state_nxt = ST_CONFIG;
          lim_nxt   = '{u: SAFE_LIMIT_U, i: SAFE_LIMIT_I,
                        p: SAFE_LIMIT_P};                          // [R5]
        end
      end
      ST_CONFIG: begin
        if (i_r_mode || (wr_cmd && i_wdata[CMD_EXIT])) begin       // [R2]
          state_nxt = ST_NORMAL;
        end else if (wr_cmd && i_wdata[CMD_LOAD]) begin
          if (cfg_ok(cfg_r)) begin                                 // [R3] [R12]
            state_nxt = ST_XFER;
          end else begin
            err_nxt = 1'b1;
          end
        end
      end
      ST_XFER: begin
        run_cfg_nxt = cfg_r;                                       // [R6] [R13]
        state_nxt   = ST_STATIC;
      end
      ST_STATIC: begin
        state_nxt = ST_OUTON;                                      // [R6]
      end
      ST_OUTON: begin
        out_on_nxt = 1'b1;                                         // [R6]
        state_nxt  = ST_ARMED;
      end
      ST_ARMED: begin
        if (cmd_start || press) begin                              // [R8]
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (press) begin                                           // [R10]
          state_nxt  = ST_CONFIG;
          out_on_nxt = 1'b0;
        end else if (cmd_stop) begin                               // [R9]
          state_nxt = ST_ARMED;
        end
      end
      default: begin
        state_nxt = ST_NORMAL;
      end
    endcase
    // Alarm outranks every command while active (ST_XFER to ST_RUN)
    if (i_alarm && active) begin                                   // [R11]
      state_nxt  = ST_CONFIG;
      out_on_nxt = 1'b0;
      alarm_nxt  = 1'b1;
    end
    rdata_nxt = '0;
    if (i_rd) begin
      if (i_addr == ADDR_CMD) begin
        rdata_nxt = {26'h0, err_r, alarm_r, out_on_r,
                     state_r == ST_RUN, state_r == ST_ARMED,
                     state_r != ST_NORMAL};
      end else if (i_addr == ADDR_FUNC) begin
        rdata_nxt = {28'h0, cfg_r.target, cfg_r.func};
      end else if (i_addr == ADDR_AMPL) begin
        rdata_nxt = {16'h0, cfg_r.ampl};
      end else if (i_addr == ADDR_OFFS) begin
        rdata_nxt = {16'h0, cfg_r.offs};
      end else if (i_addr == ADDR_FREQ) begin
        rdata_nxt = {16'h0, cfg_r.freq};
      end else if (i_addr == ADDR_FIRST) begin
        rdata_nxt = cfg_r.first_interval_time;
      end else if (i_addr == ADDR_SECOND) begin
        rdata_nxt = cfg_r.second_interval_time;
      end else if (i_addr == ADDR_STAT_U) begin
        rdata_nxt = {16'h0, stat_r.u};
      end else if (i_addr == ADDR_STAT_P) begin
        rdata_nxt = {16'h0, stat_r.p};
      end else if (i_addr == ADDR_LIM_U) begin
        rdata_nxt = {16'h0, lim_r.u};
      end else if (i_addr == ADDR_LIM_I) begin
        rdata_nxt = {16'h0, lim_r.i};
      end else if (i_addr == ADDR_LIM_P) begin
        rdata_nxt = {16'h0, lim_r.p};
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state_r   <= ST_NORMAL;
      out_on_r  <= 1'b0;
      alarm_r   <= 1'b0;
      err_r     <= 1'b0;
      cfg_r     <= CFG_RESET;
      run_cfg_r <= CFG_RESET;
      stat_r    <= '0;
      lim_r     <= '{u: SAFE_LIMIT_U, i: SAFE_LIMIT_I, p: SAFE_LIMIT_P};
      o_rdata   <= '0;
    end else begin
      state_r   <= state_nxt;
      out_on_r  <= out_on_nxt;
      alarm_r   <= alarm_nxt;
      err_r     <= err_nxt;
      cfg_r     <= cfg_nxt;
      run_cfg_r <= run_cfg_nxt;
      stat_r    <= stat_nxt;
      lim_r     <= lim_nxt;
      o_rdata   <= rdata_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Waveform engine
  logic        running;
  logic        tick;
  logic signed [15:0] sine;
  logic [31:0] phase_r,  phase_nxt;
  logic        seg_r,    seg_nxt;
  logic [31:0] cnt_r,    cnt_nxt;
  logic [15:0] ramp_r,   ramp_nxt;
  logic [47:0] err_acc_r, err_acc_nxt;
  logic [39:0] inc_wide;
  logic [31:0] seg_len;
  logic [47:0] den;
  logic signed [33:0] sine_sum;
  logic [15:0] level;
  setpoints_t  setp_nxt;

  assign running = state_r == ST_RUN;

  wave_tick #(
    .TICK_CYCLES (TICK_CYCLES_P)
  ) u_tick (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_run   (running),
    .o_tick  (tick)
  );

  sine_table u_sine (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_phase (phase_r[31:26]),
    .o_sine  (sine)
  );

  always_comb begin
    inc_wide    = {8'h0, run_cfg_r.freq} * {16'h0, PHASE_SCALE};  // [R13]
    seg_len     = seg_r ? run_cfg_r.second_interval_time
                        : run_cfg_r.first_interval_time;
    den         = 48'(seg_len) * 48'(TICK_CYCLES_P);
    phase_nxt   = phase_r + {8'h0, inc_wide[39:16]}; // 2^48 scale to 32 bits
    seg_nxt     = seg_r;
    cnt_nxt     = cnt_r;
    ramp_nxt    = ramp_r;
    err_acc_nxt = err_acc_r + 48'(run_cfg_r.ampl);
    // Slopes steeper than a code per clock snap at the interval end
    if (err_acc_nxt >= den && ramp_r < run_cfg_r.ampl) begin       // [R14]
      err_acc_nxt = err_acc_nxt - den;
      ramp_nxt    = ramp_r + 16'h1;
    end
    if (tick) begin                                                // [R20]
      cnt_nxt = cnt_r + 32'h1;
      if (cnt_nxt >= seg_len) begin                                // [R15] [R18]
        seg_nxt     = !seg_r;
        cnt_nxt     = '0;
        ramp_nxt    = '0;
        err_acc_nxt = '0;
      end
    end
    if (!running) begin
      phase_nxt   = '0;
      seg_nxt     = 1'b0;
      cnt_nxt     = '0;
      ramp_nxt    = '0;
      err_acc_nxt = '0;
    end
    sine_sum = $signed({3'b0, run_cfg_r.offs, 15'h0}) +
               $signed({2'b0, run_cfg_r.ampl}) * sine;             // [R12]
    if (run_cfg_r.func == FN_SINE) begin
      level = sine_sum[30:15];
    end else if (run_cfg_r.func == FN_TRI) begin                   // [R14] [R16]
      level = seg_r ? run_cfg_r.offs + run_cfg_r.ampl - ramp_r
                    : run_cfg_r.offs + ramp_r;
    end else begin                                                 // [R17] [R19]
      level = seg_r ? run_cfg_r.offs : run_cfg_r.offs + run_cfg_r.ampl;
    end
    // Non-target setpoints stay static and act as limits
    setp_nxt = '{u: stat_r.u, i: lim_r.i, p: stat_r.p};            // [R4]
    if (state_r != ST_NORMAL && run_cfg_r.target == TARGET_I) begin
      setp_nxt.i = running ? level : 16'h0000;                     // [R7]
    end else if (running && run_cfg_r.target == TARGET_U) begin
      setp_nxt.u = level;                                          // [R4]
    end
    setp_nxt = '{u: clamp(setp_nxt.u, lim_r.u),
                 i: clamp(setp_nxt.i, lim_r.i),
                 p: clamp(setp_nxt.p, lim_r.p)};
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      phase_r        <= '0;
      seg_r          <= 1'b0;
      cnt_r          <= '0;
      ramp_r         <= '0;
      err_acc_r      <= '0;
      o_setpoints    <= '0;
      o_limits       <= '0;
      o_output_on    <= 1'b0;
      o_running      <= 1'b0;
      o_armed        <= 1'b0;
      o_alarm_report <= 1'b0;
    end else begin
      phase_r        <= phase_nxt;
      seg_r          <= seg_nxt;
      cnt_r          <= cnt_nxt;
      ramp_r         <= ramp_nxt;
      err_acc_r      <= err_acc_nxt;
      o_setpoints    <= setp_nxt;
      o_limits       <= lim_r;
      o_output_on    <= out_on_r;
      o_running      <= running;
      o_armed        <= state_r == ST_ARMED;
      o_alarm_report <= alarm_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  chk_cfg_locked: assert property ( // [R1]
    $changed(cfg_r) |-> !$past(out_on_r))
    else $error("config changed with output on");
  chk_rmode_block: assert property ( // [R2]
    $past(i_r_mode) && $past(state_r) == ST_NORMAL |-> state_r == ST_NORMAL)
    else $error("generator entered in resistance mode");
  chk_target_set: assert property ( // [R3]
    state_r == ST_STATIC |-> run_cfg_r.target != TARGET_NONE)
    else $error("loaded without target");
  chk_load_order: assert property ( // [R6]
    (state_r == ST_XFER && !i_alarm) ##1 !i_alarm ##1 !i_alarm
      |=> state_r == ST_ARMED && out_on_r ##1 o_output_on)
    else $error("load sequence broken");
  chk_limit_reset: assert property ( // [R5]
    $past(state_r) == ST_NORMAL && state_r == ST_CONFIG
      |-> lim_r.u == SAFE_LIMIT_U && lim_r.i == SAFE_LIMIT_I &&
          lim_r.p == SAFE_LIMIT_P)
    else $error("limits not reset on entry");
  chk_i_zero: assert property ( // [R7]
    state_r == ST_ARMED && run_cfg_r.target == TARGET_I |=> o_setpoints.i == 0)
    else $error("current start level not zero");
  chk_start_now: assert property ( // [R8]
    state_r == ST_ARMED && (cmd_start || press) && !i_alarm
      |=> state_r == ST_RUN ##1 o_running)
    else $error("start not immediate");
  chk_stop_keep: assert property ( // [R9]
    state_r == ST_RUN && cmd_stop && !press && !i_alarm
      |=> state_r == ST_ARMED && out_on_r)
    else $error("stop changed output");
  chk_button_off: assert property ( // [R10]
    state_r == ST_RUN && press && !i_alarm |=> !out_on_r ##1 !o_output_on)
    else $error("button stop left output on");
  chk_alarm_abort: assert property ( // [R11]
    i_alarm && active |=> state_r == ST_CONFIG && !out_on_r && alarm_r
      ##1 !o_output_on && o_alarm_report)
    else $error("alarm did not abort");
  chk_rect_high: assert property ( // [R17]
    running && run_cfg_r.func == FN_RECT && !seg_r
      |-> level == run_cfg_r.offs + run_cfg_r.ampl)
    else $error("rectangle high level wrong");
endmodule
`default_nettype wire

// *** sim/stage_model.sv ***
/*
  Far-side model: power stage protection trip seen by the unit.
  Assumes the unit's clock and reset; trip request comes from the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module stage_model (
  input  wire logic i_clock,
  input  wire logic i_rst,
  input  wire logic i_trip_req,
  input  wire logic i_output_on,
  output logic      o_alarm
);
  // A trip can only occur while the stage is energised
  always_ff @(posedge i_clock) begin
    o_alarm <= !i_rst && i_trip_req && i_output_on;
  end
endmodule
`default_nettype wire

// *** sim/tb_setpoint_waveform_unit.sv ***
/*
  Bench for setpoint_waveform_unit over its register port.
  Assumes stage_model drives the alarm input.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_setpoint_waveform_unit;
  import wavegen_pkg::*;
  localparam int TK = 4;
  localparam logic [15:0] CV [10] = '{16'h10, 16'h20, 16'h1, 16'h2,
    16'h3, 16'h20, 16'hffff, 16'hffff, 16'hffff, 16'hffff};
  logic        i_clock = 0, i_rst = 1, i_wr = 0, i_rd = 0;
  logic [3:0]  i_addr = '0;
  logic [31:0] i_wdata = '0, o_rdata, rd_v;
  logic        i_r_mode = 0, i_onoff_button = 0, trip = 0, alarm;
  logic        o_output_on, o_running, o_armed, o_alarm_report;
  logic [1:0]  tg;
  setpoints_t  o_setpoints, o_limits;
  int          num_errors = 0, checked = 0, cyc = 0, n, p;

  always #10 i_clock = ~i_clock;

  setpoint_waveform_unit #(.TICK_CYCLES_P(TK)) u_dut (
    .i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_r_mode(i_r_mode), .i_alarm(alarm),
    .i_onoff_button(i_onoff_button), .o_output_on(o_output_on),
    .o_running(o_running), .o_armed(o_armed),
    .o_alarm_report(o_alarm_report), .o_setpoints(o_setpoints),
    .o_limits(o_limits));
  stage_model u_stage (.i_clock(i_clock), .i_rst(i_rst),
    .i_trip_req(trip), .i_output_on(o_output_on), .o_alarm(alarm));

  ////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Hang guard, far beyond the whole sequence
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      final_report();
    end
  end
  task automatic cmp(input logic [47:0] g, input logic [47:0] e);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic settle(input int c);
    repeat (c) @(posedge i_clock);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_wr <= 1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr <= 0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge i_clock);
    i_rd <= 1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd <= 0;
    #1 rd_v = o_rdata;
  endtask
  task automatic cmd(input int b);
    wr(ADDR_CMD, 32'h1 << b);
  endtask
  task automatic stat(input int b, input logic e);
    rd(ADDR_CMD);
    cmp(48'(rd_v[b]), 48'(e));
  endtask
  // Pin is synchronised, so hold it well past the two flops
  task automatic press;
    @(posedge i_clock);
    i_onoff_button <= 1;
    repeat (4) @(posedge i_clock);
    i_onoff_button <= 0;
    settle(4);
  endtask
  task automatic cfg(input logic [1:0] t);
    wr(ADDR_FUNC, 32'({t, FN_RECT}));
    for (int k = 0; k < 10; k++) wr(4'(k + 2), 32'(CV[k]));
  endtask
  function automatic logic [15:0] lvl();
    return (tg == TARGET_I) ? o_setpoints.i : o_setpoints.u;
  endfunction
  task automatic wait_lvl(input logic [15:0] v, input logic eq);
    n = 0;
    do begin
      settle(1);
      n++;
    end while (((lvl() === v) != eq) && n < 200);
  endtask

  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge i_clock);
    i_rst <= 0;
    stat(0, 0);
    @(posedge i_clock);
    i_r_mode <= 1;
    cmd(CMD_ENTER);
    stat(0, 0);
    @(posedge i_clock);
    i_r_mode <= 0;
    cmd(CMD_ENTER);
    stat(0, 1);
    cfg(TARGET_NONE);
    settle(2);
    cmp(48'(o_limits), 48'hffff_ffff_ffff);
    cmd(CMD_EXIT);
    cmd(CMD_ENTER);
    settle(2);
    cmp(48'(o_limits), {SAFE_LIMIT_U, SAFE_LIMIT_I, SAFE_LIMIT_P});
    cfg(TARGET_NONE);
    cmd(CMD_LOAD);
    stat(5, 1);
    cmd(CMD_CLR_ERR);
    $display("test entry done");
    for (int t = 1; t <= 2; t++) begin
      tg = 2'(t);
      cfg(tg);
      cmd(CMD_LOAD);
      settle(8);
      cmp(48'({o_output_on, o_armed}), 48'h3);
      cmp(48'(lvl()), (tg == TARGET_I) ? 48'h0 : 48'h20);
      wr(ADDR_FUNC, 32'(FN_RECT));
      if (tg == TARGET_U) cmd(CMD_START);
      else press();
      wait_lvl(16'h30, 1);
      cmp(48'(n < 20), 48'h1);
      cmp(48'(o_setpoints.u), (tg == TARGET_I) ? 48'h20 : 48'h30);
      // Whole segments only, the first high one carries start skew
      wait_lvl(16'h30, 0);
      wait_lvl(16'h30, 1);
      p = n;
      wait_lvl(16'h30, 0);
      cmp(48'(n), 48'(2 * TK));
      cmp(48'(p + n), 48'(5 * TK));
      cmd(CMD_STOP);
      settle(3);
      cmp(48'({o_running, o_output_on}), 48'h1);
      cmd(CMD_START);
      settle(3);
      press();
      cmp(48'({o_running, o_output_on}), 48'h0);
      $display("test rectangle target %0d done", t);
    end
    cmd(CMD_LOAD);
    settle(8);
    cmp(48'(o_armed), 48'h1);
    cmd(CMD_START);
    settle(4);
    trip <= 1;
    settle(4);
    cmp(48'({o_output_on, o_running, o_alarm_report}), 48'h1);
    trip <= 0;
    stat(4, 1);
    cmd(CMD_CLR_ALARM);
    stat(4, 0);
    $display("test alarm done");
    tg = TARGET_U;
    wr(ADDR_FUNC, 32'({TARGET_U, FN_TRI}));
    cmd(CMD_LOAD);
    settle(8);
    cmd(CMD_START);
    // Peak shows only where the falling interval begins
    wait_lvl(16'h30, 1);
    wait_lvl(16'h30, 0);
    cmp(48'(lvl()), 48'h2f);
    p = n;
    wait_lvl(16'h30, 1);
    cmp(48'(p + n), 48'(5 * TK));
    press();
    $display("test triangle done");
    wr(ADDR_FUNC, 32'({TARGET_U, FN_SINE}));
    wr(ADDR_FREQ, 32'(FREQ_MAX));
    cmd(CMD_LOAD);
    settle(8);
    cmd(CMD_START);
    // Quarter and half period; table peak is one code short
    settle(1290);
    cmp(48'(lvl() inside {16'h2f, 16'h30}), 48'h1);
    settle(1250);
    cmp(48'(lvl()), 48'h20);
    $display("test sine done");
    final_report();
  end
endmodule
`default_nettype wire
